// ### bench/testbench.sv
// testbench: timer output levels across count stops and mode changes
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tom_pkg::*;
();
  logic core_clk;
  logic nrst;
  logic waitrequest;
  logic [9:0] cmpMatch, tmrOut, pinOut, pinOe;
  logic [31:0] readdata, rv;
  tom_avl_req_t avlReq;
  int fails = 0, checkCount = 0, cycles = 0;
  tom_output_ctrl tom_output_ctrl_inst (
    .core_clk(core_clk), .nrst(nrst), .avlReq(avlReq), .cmpMatch(cmpMatch),
    .waitrequest(waitrequest), .readdata(readdata), .tmrOut(tmrOut),
    .pinOut(pinOut), .pinOe(pinOe));
  tom_host tom_host_inst (
    .core_clk(core_clk), .waitrequest(waitrequest), .readdata(readdata),
    .avlReq(avlReq));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pchk(input logic [3:0] e);
    chk(32'(tmrOut[9:6]), 32'(e));
  endtask
  // one-cycle compare events
  task automatic pulse(input logic [9:0] m);
    cmpMatch <= m;
    @(posedge core_clk);
    cmpMatch <= '0;
    @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    chk(32'(tmrOut), 32'h0);
    chk(32'(pinOe), 32'h0);
    chk(32'(pinOut), 32'h0);
    tom_host_inst.rd(5'h02, rv);
    chk(rv, RD_UNMAPPED);
    tom_host_inst.rd(OFS_STAT, rv);
    chk(rv, 32'h0);
    $display("test reset done");
  endtask
  // refused codes keep the old field
  task automatic t_modes();
    logic [31:0] m [6] = '{32'h02, 32'h36, 32'h42, 32'h04, 32'h51, 32'h03};
    logic [31:0] e [6] = '{32'h02, 32'h02, 32'h02, 32'h04, 32'h04, 32'h03};
    for (int i = 0; i < 6; i++) begin
      tom_host_inst.wr(OFS_MODE, m[i]);
      tom_host_inst.rd(OFS_MODE, rv);
      chk(rv, e[i]);
    end
    $display("test mode codes done");
  endtask
  task automatic t_low();
    tom_host_inst.wr(OFS_MODE, 32'h02);
    tom_host_inst.restart(3'h2, 1'b1, 32'h3FF, 5'h01);
    chk(32'(tmrOut), 32'h3D5);
    chk(32'(pinOe), 32'h03F);
    pulse(10'h001);
    chk(32'(tmrOut), 32'h3D4);
    tom_host_inst.err_stop(10'h2AA);
    chk(32'(pinOut), 32'h2AA);
    chk(32'(pinOe), 32'h3FF);
    tom_host_inst.restart(3'h3, 1'b0, 32'h0, 5'h01);
    chk(32'(tmrOut), 32'h014);
    tom_host_inst.wr(OFS_START, 32'h0);
    $display("test low channel modes done");
  endtask
  task automatic t_comp();
    tom_host_inst.pair_start(3'h6, 1'b0, 9'h105);
    chk(32'(pinOe), 32'h3FF);
    pulse(10'h0C0);
    pchk(4'h3);
    chk(32'(pinOut), 32'h0D4);
    tom_host_inst.rd(OFS_STAT, rv);
    chk(32'(rv[17:16]), 32'h1);
    tom_host_inst.err_stop(10'h0);
    pchk(4'h5);
    tom_host_inst.rd(OFS_STAT, rv);
    chk(32'(rv[17:16]), 32'h3);
    tom_host_inst.pair_resume();
    pulse(10'h100);
    pchk(4'h9);
    tom_host_inst.wr(OFS_START, 32'h0);
    pchk(4'h5);
    for (int i = 0; i < 2; i++) begin
      tom_host_inst.wr(OFS_MODE, 32'h60);
      tom_host_inst.wr(OFS_MODE, (i == 0) ? 32'h00 : 32'h20);
      pchk(4'h0);
    end
    $display("test complementary pair done");
  endtask
  task automatic t_rsync();
    tom_host_inst.pair_start(3'h7, 1'b1, 9'h007);
    pulse(10'h040);
    pchk(4'h6);
    pulse(10'h080);
    pchk(4'hC);
    tom_host_inst.wr(OFS_START, 32'h0);
    pchk(4'h7);
    tom_host_inst.pair_start(3'h6, 1'b0, 9'h107);
    pchk(4'h6);
    tom_host_inst.wr(OFS_START, 32'h0);
    pchk(4'h7);
    for (int i = 0; i < 2; i++) begin
      tom_host_inst.wr(OFS_MODE, 32'h70);
      tom_host_inst.wr(OFS_MODE, (i == 0) ? 32'h00 : 32'h20);
      pchk(4'h8);
    end
    $display("test reset-synchronous pair done");
  endtask
  initial begin
    nrst = 1'b0;
    cmpMatch = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_modes();
    t_low();
    t_comp();
    t_rsync();
    report_and_stop();
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire

// ### bench/tom_host.sv
// host model: bus master tasks and recovery sequences
`timescale 1ns/1ps
`default_nettype none
module tom_host
  import tom_pkg::*;
(
  input wire logic core_clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output var tom_avl_req_t avlReq
);
  initial avlReq = '0;
  // request held until waitrequest is sampled low
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    avlReq <= '{1'b0, 1'b1, a, d, 4'hF};
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    avlReq.write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    avlReq <= '{1'b1, 1'b0, a, 32'h0, 4'hF};
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    d = readdata;
    avlReq.read <= 1'b0;
    @(posedge core_clk);
  endtask
  // port drives inverse level before the count stops
  task automatic err_stop(input logic [9:0] inv);
    wr(OFS_PORT, {6'h0, 10'h3FF, 6'h0, inv});
    wr(OFS_PINSEL, 32'h0);
    wr(OFS_START, 32'h0);
  endtask
  // same-mode restart skips the mode write
  task automatic restart(input logic [2:0] m, input logic same, input logic [31:0] io,
      input logic [4:0] st);
    if (!same) wr(OFS_MODE, {29'h0, m});
    wr(OFS_IOCTL, io);
    wr(OFS_PINSEL, 32'h3FF);
    wr(OFS_START, {27'h0, st});
  endtask
  task automatic pair_resume();
    wr(OFS_PINSEL, 32'h3FF);
    wr(OFS_START, 32'h18);
  endtask
  // pair outputs off around the mode change
  task automatic pair_start(input logic [2:0] m, input logic viaNormal, input logic [8:0] lvl);
    if (viaNormal) wr(OFS_MODE, 32'h0);
    wr(OFS_OUTEN, 32'h0);
    wr(OFS_LEVEL, {23'h0, lvl});
    wr(OFS_MODE, {25'h0, m, 4'h0});
    wr(OFS_OUTEN, 32'hF);
    pair_resume();
  endtask
endmodule
`default_nettype wire

// ### hdl/tom_avl_slave.sv
// file: Avalon-MM slave handshake with one wait cycle per access
`timescale 1ns/1ps
`default_nettype none
module tom_avl_slave
  import tom_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire tom_avl_req_t avlReq,
  input wire logic [31:0] rdValue,
  output logic waitrequest,
  output logic [31:0] readdata,
  output logic wrStrobe
);
  typedef struct packed {
    logic wait_;
    logic [31:0] rdata;
  } tom_slv_t;

  tom_slv_t s;
  tom_slv_t next_s;

  always_comb begin
    next_s = s;
    if (!s.wait_) begin
      next_s.wait_ = 1'b1;
    end else if (avlReq.read || avlReq.write) begin
      // drop waitrequest next cycle, read data already standing
      next_s.wait_ = 1'b0;
      next_s.rdata = avlReq.read ? rdValue : s.rdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{wait_: 1'b1, rdata: 32'h00000000};
    end else begin
      s <= next_s;
    end
  end

  assign waitrequest = s.wait_;
  assign readdata = s.rdata;
  assign wrStrobe = avlReq.write && !s.wait_;
endmodule
`default_nettype wire

// ### hdl/tom_output_ctrl.sv
// file: timer output level control across mode changes and count stops
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - after reset timer outputs low, pins undriven until a pin function is chosen
// - halting count in complementary PWM loads programmed initial pair levels
// - complementary PWM to normal while stopped drives pair outputs low
// - complementary PWM to PWM mode 1 while stopped drives pair outputs low
// - halting count in reset-synchronous PWM loads programmed initial pair levels
// - reset-synchronous PWM to normal or PWM 1 while stopped: positive low, negative high
// - reset-synchronous PWM to complementary PWM while stopped drives the cyclic pin low
// - in PWM mode 1 pin initialisation touches only A-side outputs
// - in PWM mode 2 pin initialisation skips the cycle-register pin
// - running pair PWM modes change outputs at compare matches
// - PWM mode 2 exists only on channels 0 to 2
// - phase counting exists only on the low channels
module tom_output_ctrl
  import tom_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire tom_avl_req_t avlReq,
  input wire logic [9:0] cmpMatch,
  output logic waitrequest,
  output logic [31:0] readdata,
  output logic [9:0] tmrOut,
  output logic [9:0] pinOut,
  output logic [9:0] pinOe
);
  typedef struct packed {
    tom_mode_t modeLo;
    tom_mode_t modeHi;
    logic [4:0] start;
    logic [3:0] outEn;
    logic [3:0] pairInit;
    logic cycEn;
    logic [9:0] initLvl;
    logic [9:0] matchLvl;
    logic [9:0] pinSel;
    logic [9:0] portData;
    logic [9:0] portDrv;
    logic [9:0] tmrOut;
    tom_pair_t pairSt;
    logic [9:0] pinOut;
    logic [9:0] pinOe;
  } tom_state_t;

  localparam tom_state_t ST_RESET = '{
    modeLo: MODE_NORMAL, modeHi: MODE_NORMAL, start: 5'h00, outEn: 4'h0,
    pairInit: 4'h0, cycEn: 1'b0, initLvl: 10'h000, matchLvl: 10'h000,
    pinSel: 10'h000, portData: 10'h000, portDrv: 10'h000, tmrOut: 10'h000,
    pairSt: PAIR_STOP, pinOut: 10'h000, pinOe: 10'h000};

  tom_state_t s;
  tom_state_t next_s;
  logic [31:0] rdValue;
  logic [31:0] wd;
  logic wrStrobe;
  logic [3:0] pairNext;
  logic pairRun;
  logic pairPwm;
  tom_mode_t newLo;
  tom_mode_t newHi;

  function automatic logic [31:0] tom_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic tom_lo_ok(input tom_mode_t m);
    return (m == MODE_NORMAL) || (m == MODE_PWM1) || (m == MODE_PWM2) || (m == MODE_PHASE);
  endfunction

  function automatic logic tom_hi_ok(input tom_mode_t m);
    return (m == MODE_NORMAL) || (m == MODE_PWM1) || (m == MODE_COMP) || (m == MODE_RSYNC);
  endfunction

  tom_avl_slave u_slave (
    .core_clk(core_clk),
    .nrst(nrst),
    .avlReq(avlReq),
    .rdValue(rdValue),
    .waitrequest(waitrequest),
    .readdata(readdata),
    .wrStrobe(wrStrobe)
  );

  tom_pair_wave u_pair (
    .mode(s.modeHi),
    .cur(s.tmrOut[9:6]),
    .cmp(cmpMatch[9:6]),
    .cycEn(s.cycEn),
    .nxt(pairNext)
  );

  // register readback, also the old value for byte-lane merging
  always_comb begin
    case (avlReq.address)
      OFS_MODE: rdValue = {25'h0, s.modeHi, 1'b0, s.modeLo};
      OFS_START: rdValue = {27'h0, s.start};
      OFS_OUTEN: rdValue = {28'h0, s.outEn};
      OFS_LEVEL: rdValue = {23'h0, s.cycEn, 4'h0, s.pairInit};
      OFS_IOCTL: rdValue = {6'h0, s.matchLvl, 6'h0, s.initLvl};
      OFS_PINSEL: rdValue = {22'h0, s.pinSel};
      OFS_PORT: rdValue = {6'h0, s.portDrv, 6'h0, s.portData};
      OFS_STAT: rdValue = {14'h0, s.pairSt, 6'h0, s.tmrOut};
      default: rdValue = RD_UNMAPPED;
    endcase
  end

  assign wd = tom_merge(rdValue, avlReq.writedata, avlReq.byteenable);
  assign pairRun = s.start[3] || s.start[4];
  assign pairPwm = (s.modeHi == MODE_COMP) || (s.modeHi == MODE_RSYNC);
  assign newLo = tom_mode_t'(wd[MODE_LO_LSB +: 3]);
  assign newHi = tom_mode_t'(wd[MODE_HI_LSB +: 3]);

  always_comb begin
    next_s = s;
    // compare events on pins outside the pair PWM modes
    for (int i = 0; i < NPIN; i++) begin
      if (s.start[i / 2] && cmpMatch[i] && !(i >= PAIR_LSB && pairPwm)) begin
        next_s.tmrOut[i] = s.matchLvl[i];
      end
    end
    if (pairRun && pairPwm) begin
      next_s.tmrOut[9:6] = pairNext;
    end
    if (wrStrobe) begin
      case (avlReq.address)
        OFS_MODE: begin
          if (tom_lo_ok(newLo)) begin
            next_s.modeLo = newLo;
          end
          // pair modes refuse PWM 2 and phase counting
          if (tom_hi_ok(newHi)) begin
            next_s.modeHi = newHi;
            if (!pairRun && newHi != s.modeHi) begin
              if (s.modeHi == MODE_COMP && (newHi == MODE_NORMAL || newHi == MODE_PWM1)) begin
                next_s.tmrOut[9:6] = PAIR_LOW;
              end
              if (s.modeHi == MODE_RSYNC && (newHi == MODE_NORMAL || newHi == MODE_PWM1)) begin
                next_s.tmrOut[9:6] = PAIR_NEG_MASK;
              end
              if (s.modeHi == MODE_RSYNC && newHi == MODE_COMP) begin
                next_s.tmrOut[PAIR_LSB + PAIR_CYC] = 1'b0;
              end
            end
          end
        end
        OFS_START: begin
          next_s.start = wd[4:0];
          if (pairRun && pairPwm && !(wd[3] || wd[4])) begin
            next_s.tmrOut[9:6] = s.pairInit;
          end
        end
        OFS_OUTEN: next_s.outEn = wd[3:0];
        OFS_LEVEL: begin
          next_s.pairInit = wd[3:0];
          next_s.cycEn = wd[LVL_CYC_BIT];
        end
        OFS_IOCTL: begin
          next_s.initLvl = wd[9:0];
          next_s.matchLvl = wd[HI_LSB +: 10];
          for (int i = 0; i < NPIN; i++) begin
            if (i < PAIR_LSB) begin
              if (!(s.modeLo == MODE_PWM1 && i % 2 == 1) &&
                  !(s.modeLo == MODE_PWM2 && i % 2 == 0)) begin
                next_s.tmrOut[i] = wd[i];
              end
            end else if (!pairPwm && !(s.modeHi == MODE_PWM1 && i % 2 == 1)) begin
              next_s.tmrOut[i] = wd[i];
            end
          end
        end
        OFS_PINSEL: next_s.pinSel = wd[9:0];
        OFS_PORT: begin
          next_s.portData = wd[9:0];
          next_s.portDrv = wd[HI_LSB +: 10];
        end
        default: begin
        end
      endcase
    end
    case (s.pairSt)
      PAIR_STOP: next_s.pairSt = (next_s.start[3] || next_s.start[4]) ? PAIR_RUN : PAIR_STOP;
      PAIR_RUN: next_s.pairSt = (next_s.start[3] || next_s.start[4]) ? PAIR_RUN : PAIR_HALT;
      PAIR_HALT: next_s.pairSt = (next_s.start[3] || next_s.start[4]) ? PAIR_RUN : PAIR_HALT;
      default: next_s.pairSt = PAIR_STOP;
    endcase
    // registered pin mux, so a level change never glitches
    for (int i = 0; i < NPIN; i++) begin
      next_s.pinOut[i] = next_s.pinSel[i] ? next_s.tmrOut[i] : next_s.portData[i];
      if (next_s.pinSel[i]) begin
        next_s.pinOe[i] = (i < PAIR_LSB) ? 1'b1 : next_s.outEn[i - PAIR_LSB];
      end else begin
        next_s.pinOe[i] = next_s.portDrv[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign tmrOut = s.tmrOut;
  assign pinOut = s.pinOut;
  assign pinOe = s.pinOe;

  // checks
  logic wrMode;
  logic wrStart;
  logic wrIoctl;
  assign wrMode = wrStrobe && avlReq.address == OFS_MODE;
  assign wrStart = wrStrobe && avlReq.address == OFS_START;
  assign wrIoctl = wrStrobe && avlReq.address == OFS_IOCTL;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_pin_hiz_unsel: assert property ((s.pinOe & ~(s.pinSel | s.portDrv)) == 10'h000)
    else $error("pin driven without a selected function");
  a_comp_halt_init: assert property (wrStart && pairRun && s.modeHi == MODE_COMP &&
      !(wd[3] || wd[4]) |=> s.tmrOut[9:6] == $past(s.pairInit) && s.pairSt == PAIR_HALT)
    else $error("complementary halt did not load initial levels");
  a_comp_to_normal: assert property (wrMode && !pairRun && s.modeHi == MODE_COMP &&
      newHi == MODE_NORMAL |=> s.tmrOut[9:6] == PAIR_LOW)
    else $error("pair not low after complementary to normal");
  a_comp_to_pwm1: assert property (wrMode && !pairRun && s.modeHi == MODE_COMP &&
      newHi == MODE_PWM1 |=> s.tmrOut[9:6] == PAIR_LOW && s.modeHi == MODE_PWM1)
    else $error("pair not low after complementary to PWM 1");
  a_rsync_halt_init: assert property (wrStart && pairRun && s.modeHi == MODE_RSYNC &&
      !(wd[3] || wd[4]) |=> s.tmrOut[9:6] == $past(s.pairInit))
    else $error("reset-synchronous halt did not load initial levels");
  a_rsync_leave: assert property (wrMode && !pairRun && s.modeHi == MODE_RSYNC &&
      (newHi == MODE_NORMAL || newHi == MODE_PWM1) |=> s.tmrOut[9:6] == PAIR_NEG_MASK)
    else $error("phases wrong after leaving reset-synchronous mode");
  a_rsync_to_comp: assert property (wrMode && !pairRun && s.modeHi == MODE_RSYNC &&
      newHi == MODE_COMP |=> !s.tmrOut[PAIR_LSB + PAIR_CYC] && s.modeHi == MODE_COMP)
    else $error("cyclic pin not low entering complementary mode");
  a_pwm1_b_kept: assert property (wrIoctl && s.modeLo == MODE_PWM1 && cmpMatch == 10'h000
      |=> (s.tmrOut & LO_B_MASK) == ($past(s.tmrOut) & LO_B_MASK))
    else $error("B side initialised in PWM 1");
  a_pwm2_cyc_kept: assert property (wrIoctl && s.modeLo == MODE_PWM2 && cmpMatch == 10'h000
      |=> (s.tmrOut & LO_A_MASK) == ($past(s.tmrOut) & LO_A_MASK))
    else $error("cycle pin initialised in PWM 2");
  a_comp_wave: assert property (pairRun && s.modeHi == MODE_COMP && cmpMatch[7] && !wrStrobe
      |=> s.tmrOut[7] != $past(s.tmrOut[7]) && s.tmrOut[9] == !s.tmrOut[7])
    else $error("complementary waveform did not follow compare match");
  a_hi_no_pwm2: assert property (wrMode && (newHi == MODE_PWM2 || newHi == MODE_PHASE)
      |=> $stable(s.modeHi))
    else $error("pair accepted a low-channel-only mode");
  a_pin_follow: assert property (wrStrobe && avlReq.address == OFS_PINSEL |=>
      s.pinOut == ((s.pinSel & s.tmrOut) | (~s.pinSel & s.portData)))
    else $error("pin level not updated on the edge after the write");

  c_comp_stop: cover property (pairRun && s.modeHi == MODE_COMP ##1 !pairRun);
  c_rsync_to_comp: cover property (s.modeHi == MODE_RSYNC ##1 s.modeHi == MODE_COMP);
  c_pwm1_init: cover property (wrIoctl && s.modeLo == MODE_PWM1);
  c_restart: cover property (s.pairSt == PAIR_HALT ##1 s.pairSt == PAIR_RUN);
endmodule
`default_nettype wire

// ### hdl/tom_pair_wave.sv
// file: next-level logic of the channel 3/4 pair in the two pair PWM modes
`timescale 1ns/1ps
`default_nettype none
module tom_pair_wave
  import tom_pkg::*;
(
  input wire tom_mode_t mode,
  input wire logic [3:0] cur,
  input wire logic [3:0] cmp,
  input wire logic cycEn,
  output logic [3:0] nxt
);
  always_comb begin
    nxt = cur;
    if (cycEn && cmp[PAIR_CYC]) begin
      nxt[PAIR_CYC] = ~cur[PAIR_CYC];
    end
    if (mode == MODE_RSYNC) begin
      // period reset raises, duty match lowers
      if (cmp[PAIR_CYC]) begin
        nxt[PAIR_U] = 1'b1;
        nxt[PAIR_V] = 1'b1;
      end
      if (cmp[PAIR_U]) begin
        nxt[PAIR_U] = 1'b0;
      end
      if (cmp[PAIR_V]) begin
        nxt[PAIR_V] = 1'b0;
      end
    end else begin
      if (cmp[PAIR_U]) begin
        nxt[PAIR_U] = ~cur[PAIR_U];
      end
      if (cmp[PAIR_V]) begin
        nxt[PAIR_V] = ~cur[PAIR_V];
      end
    end
    nxt[PAIR_UN] = ~nxt[PAIR_U];
  end
endmodule
`default_nettype wire

// ### hdl/tom_pkg.sv
// package: shared constants and types of the timer output mode block
package tom_pkg;
  localparam int unsigned NPIN = 10;
  localparam int unsigned NCH = 5;
  localparam int unsigned ADDR_W = 5;
  // register byte offsets
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_START = 5'h04;
  localparam logic [4:0] OFS_OUTEN = 5'h08;
  localparam logic [4:0] OFS_LEVEL = 5'h0C;
  localparam logic [4:0] OFS_IOCTL = 5'h10;
  localparam logic [4:0] OFS_PINSEL = 5'h14;
  localparam logic [4:0] OFS_PORT = 5'h18;
  localparam logic [4:0] OFS_STAT = 5'h1C;
  // field positions
  localparam int unsigned MODE_LO_LSB = 0;
  localparam int unsigned MODE_HI_LSB = 4;
  localparam int unsigned LVL_CYC_BIT = 8;
  localparam int unsigned HI_LSB = 16;
  localparam int unsigned PAIR_LSB = 6;
  // pair pins: bit0 cyclic, bit1/bit2 positive phase, bit3 negative phase
  localparam int unsigned PAIR_CYC = 0;
  localparam int unsigned PAIR_U = 1;
  localparam int unsigned PAIR_V = 2;
  localparam int unsigned PAIR_UN = 3;
  localparam logic [3:0] PAIR_NEG_MASK = 4'h8;
  localparam logic [3:0] PAIR_LOW = 4'h0;
  localparam logic [9:0] LO_A_MASK = 10'h015;
  localparam logic [9:0] LO_B_MASK = 10'h02A;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PWM1 = 3'h2,
    MODE_PWM2 = 3'h3,
    MODE_PHASE = 3'h4,
    MODE_COMP = 3'h6,
    MODE_RSYNC = 3'h7
  } tom_mode_t;

  typedef enum logic [1:0] {
    PAIR_STOP = 2'b00,
    PAIR_RUN = 2'b01,
    PAIR_HALT = 2'b11
  } tom_pair_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tom_avl_req_t;
endpackage
